// ### logic/dhr_pkg.sv
package dhr_pkg;
  // Command codes received from the host
  localparam logic [7:0] CMD_SET_CFG0 = 8'h81;
  localparam logic [7:0] CMD_GET_CFG0 = 8'h82;
  localparam logic [7:0] CMD_STATUS0 = 8'h85;
  localparam logic [7:0] CMD_STATUS1 = 8'h86;
  // Response code low bits and class bits
  localparam logic [5:0] MSG_SET_CFG0 = 6'h01;
  localparam logic [5:0] MSG_GET_CFG0 = 6'h02;
  localparam logic [5:0] MSG_STATUS0 = 6'h05;
  localparam logic [5:0] MSG_STATUS1 = 6'h06;
  localparam logic [1:0] CLS_NACK = 2'h0;
  localparam logic [1:0] CLS_ACK = 2'h1;
  localparam logic [1:0] CLS_UNSOL = 2'h2;
  // Status 0 bit positions
  localparam int S0_TEMP_WARN = 0;
  localparam int S0_OVER_TEMP = 1;
  localparam int S0_IN_UV = 2;
  localparam int S0_IN_OV = 4;
  localparam int S0_BUCK_OC = 5;
  localparam int S0_BUCK_UVW = 6;
  localparam int S0_BUCK_UVE = 7;
  // Status 1 bit positions
  localparam int S1_LIN5_OC = 0;
  localparam int S1_LIN12_OC = 1;
  localparam int S1_GATE_UV_LOCKOUT = 2;
  localparam int S1_EXT_OC = 3;
  localparam int S1_CFG_LOST = 4;
  // Protection config fields
  localparam int CFG_PULLUP_DISC = 6;
  localparam int CFG_UV_LOCKOUT_DIS = 3;
  localparam int CFG_OC_DIS = 2;
  localparam int CFG_OC_THR_LSB = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h4f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic CFG_LOST_RESET = 1'b1;
  typedef enum logic [1:0] {DHR_IDLE, DHR_BYTE1, DHR_BYTE2} dhr_state_t;
endpackage

// ### logic/dhr_encoder.sv
`timescale 1ns/1ps
module dhr_encoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_reject,
  output logic cmd_ready,
  input wire logic link_busy,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic brownout_event,
  input wire logic flt_temp_warn,
  input wire logic flt_over_temp,
  input wire logic flt_in_uv,
  input wire logic flt_in_ov,
  input wire logic flt_buck_oc,
  input wire logic flt_buck_uv_warn,
  input wire logic flt_buck_uv_err,
  input wire logic flt_lin5_oc,
  input wire logic flt_lin12_oc,
  input wire logic flt_gate_undervoltage_lockout,
  input wire logic flt_ext_oc,
  input wire logic unsol_status0_req,
  output logic cfg_pullup_disc,
  output logic cfg_uv_lockout_dis,
  output logic cfg_oc_dis,
  output logic [1:0] cfg_oc_thr
);
  dhr_pkg::dhr_state_t state_q, state_d;
  logic [7:0] byte1_q, byte1_d;
  logic [7:0] byte2_q, byte2_d;
  logic [5:0] kind_q, kind_d;
  logic ack_q, ack_d;
  logic [7:0] cfg_q, cfg_d;
  logic lost_q, lost_d;
  logic unsol1_q, unsol1_d;
  logic unsol0_q, unsol0_d;
  logic [7:0] status0;
  logic [7:0] status1;
  logic take_cmd;
  logic take_unsol;
  logic clear_lost;

  function automatic logic [7:0] resp_code(input logic [1:0] cls, input logic [5:0] kind);
    resp_code = {cls, kind};
  endfunction

  always_comb begin
    status0 = 8'h00;
    status0[dhr_pkg::S0_TEMP_WARN] = flt_temp_warn;
    status0[dhr_pkg::S0_OVER_TEMP] = flt_over_temp;
    status0[dhr_pkg::S0_IN_UV] = flt_in_uv;
    status0[dhr_pkg::S0_IN_OV] = flt_in_ov;
    status0[dhr_pkg::S0_BUCK_OC] = flt_buck_oc;
    status0[dhr_pkg::S0_BUCK_UVW] = flt_buck_uv_warn;
    status0[dhr_pkg::S0_BUCK_UVE] = flt_buck_uv_err;
    status1 = 8'h00;
    status1[dhr_pkg::S1_LIN5_OC] = flt_lin5_oc;
    status1[dhr_pkg::S1_LIN12_OC] = flt_lin12_oc;
    status1[dhr_pkg::S1_GATE_UV_LOCKOUT] = flt_gate_undervoltage_lockout;
    status1[dhr_pkg::S1_EXT_OC] = flt_ext_oc;
    status1[dhr_pkg::S1_CFG_LOST] = lost_q;
  end

  assign cmd_ready = (state_q == dhr_pkg::DHR_IDLE);
  assign take_cmd = cmd_ready && cmd_valid;
  // Host commands take priority; pending reports wait for an idle link
  assign take_unsol = cmd_ready && !cmd_valid && !link_busy && (unsol1_q || unsol0_q);
  assign tx_valid = (state_q != dhr_pkg::DHR_IDLE);
  assign tx_byte = (state_q == dhr_pkg::DHR_BYTE2) ? byte2_q : byte1_q;
  assign cfg_pullup_disc = cfg_q[dhr_pkg::CFG_PULLUP_DISC];
  assign cfg_uv_lockout_dis = cfg_q[dhr_pkg::CFG_UV_LOCKOUT_DIS];
  assign cfg_oc_dis = cfg_q[dhr_pkg::CFG_OC_DIS];
  assign cfg_oc_thr = cfg_q[dhr_pkg::CFG_OC_THR_LSB +: 2];
  assign clear_lost = (state_q == dhr_pkg::DHR_BYTE1) && tx_ready && ack_q &&
                      (kind_q == dhr_pkg::MSG_STATUS1);

  always_comb begin
    state_d = state_q;
    byte1_d = byte1_q;
    byte2_d = byte2_q;
    kind_d = kind_q;
    ack_d = ack_q;
    cfg_d = cfg_q;
    lost_d = lost_q;
    unsol1_d = unsol1_q;
    unsol0_d = unsol0_q;
    case (state_q)
      dhr_pkg::DHR_IDLE: begin
        if (take_cmd) begin
          state_d = dhr_pkg::DHR_BYTE1;
          ack_d = !cmd_reject;
          byte2_d = 8'h00;
          case (cmd_code)
            dhr_pkg::CMD_STATUS0: begin
              kind_d = dhr_pkg::MSG_STATUS0;
            end
            dhr_pkg::CMD_STATUS1: begin
              kind_d = dhr_pkg::MSG_STATUS1;
            end
            dhr_pkg::CMD_SET_CFG0: begin
              kind_d = dhr_pkg::MSG_SET_CFG0;
              // Reserved bits are dropped so the echo reads them as zero
              if (!cmd_reject) begin
                cfg_d = cmd_data & dhr_pkg::CFG_WRITE_MASK;
              end
            end
            dhr_pkg::CMD_GET_CFG0: begin
              kind_d = dhr_pkg::MSG_GET_CFG0;
            end
            default: begin
              // Unknown codes are other blocks' business; answer nothing
              state_d = dhr_pkg::DHR_IDLE;
            end
          endcase
          byte1_d = resp_code(cmd_reject ? dhr_pkg::CLS_NACK : dhr_pkg::CLS_ACK, kind_d);
        end else if (take_unsol) begin
          state_d = dhr_pkg::DHR_BYTE1;
          ack_d = 1'b0;
          if (unsol1_q) begin
            kind_d = dhr_pkg::MSG_STATUS1;
            unsol1_d = 1'b0;
            byte1_d = resp_code(dhr_pkg::CLS_UNSOL, dhr_pkg::MSG_STATUS1);
          end else begin
            kind_d = dhr_pkg::MSG_STATUS0;
            unsol0_d = 1'b0;
            byte1_d = resp_code(dhr_pkg::CLS_UNSOL, dhr_pkg::MSG_STATUS0);
          end
        end
      end
      dhr_pkg::DHR_BYTE1: begin
        if (tx_ready) begin
          state_d = dhr_pkg::DHR_BYTE2;
          // Data byte is formed only now so it carries current flags
          case (kind_q)
            dhr_pkg::MSG_STATUS0: byte2_d = status0;
            dhr_pkg::MSG_STATUS1: byte2_d = status1;
            default: byte2_d = cfg_q;
          endcase
        end
      end
      dhr_pkg::DHR_BYTE2: begin
        if (tx_ready) begin
          state_d = dhr_pkg::DHR_IDLE;
        end
      end
      default: begin
        state_d = dhr_pkg::DHR_IDLE;
      end
    endcase
    // A new request in the sending cycle wins so it is not swallowed
    if (unsol_status0_req) begin
      unsol0_d = 1'b1;
    end
    if (clear_lost) begin
      lost_d = 1'b0;
    end
    // A brown-out in the clearing cycle wins so the loss is never hidden
    if (brownout_event) begin
      lost_d = 1'b1;
      // The host saw the flag cleared, so it must hear of the new loss
      if (!lost_q || clear_lost) begin
        unsol1_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= dhr_pkg::DHR_IDLE;
      byte1_q <= 8'h00;
      byte2_q <= 8'h00;
      kind_q <= dhr_pkg::MSG_STATUS0;
      ack_q <= 1'b0;
      cfg_q <= dhr_pkg::CFG_RESET;
      lost_q <= dhr_pkg::CFG_LOST_RESET;
      unsol1_q <= 1'b1;
      unsol0_q <= 1'b0;
    end else begin
      state_q <= state_d;
      byte1_q <= byte1_d;
      byte2_q <= byte2_d;
      kind_q <= kind_d;
      ack_q <= ack_d;
      cfg_q <= cfg_d;
      lost_q <= lost_d;
      unsol1_q <= unsol1_d;
      unsol0_q <= unsol0_d;
    end
  end
endmodule

// ### bench/dhr_encoder_monitor.sv
`timescale 1ns/1ps
module dhr_encoder_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_reject,
  input wire logic cmd_ready,
  input wire logic link_busy,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic cfg_pullup_disc,
  input wire logic cfg_uv_lockout_dis,
  input wire logic cfg_oc_dis,
  input wire logic [1:0] cfg_oc_thr
);
  logic b2_q;
  logic b2_d;
  wire logic take_w = cmd_valid && cmd_ready;
  always_comb b2_d = (tx_valid && tx_ready) ? !b2_q : b2_q;
  always_ff @(posedge ref_clk) b2_q <= rst_n ? b2_d : 1'b0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  s0_ack_a: assert property (take_w && cmd_code == 8'h85 && !cmd_reject |=> tx_valid && tx_byte == 8'h45)
    else $error("status0 ack code wrong");
  s1_nack_a: assert property (take_w && cmd_code == 8'h86 && cmd_reject |=> tx_valid && tx_byte == 8'h06)
    else $error("status1 nack code wrong");
  set_code_a: assert property (take_w && cmd_code == 8'h81 |=> tx_byte == ($past(cmd_reject) ? 8'h01 : 8'h41))
    else $error("set answer code wrong");
  get_code_a: assert property (take_w && cmd_code == 8'h82 && !cmd_reject |=> tx_byte == 8'h42)
    else $error("get answer code wrong");
  byte_stands_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("offered byte changed");
  busy_refuse_a: assert property (tx_valid |-> !cmd_ready)
    else $error("command taken mid message");
  two_bytes_a: assert property (tx_valid && tx_ready |=> tx_valid == b2_q)
    else $error("message not two bytes");
  cfg_echo_a: assert property (tx_valid && tx_ready && !b2_q && tx_byte inside {8'h41, 8'h42} |=>
    tx_byte == {1'b0, cfg_pullup_disc, 2'b00, cfg_uv_lockout_dis, cfg_oc_dis, cfg_oc_thr}) else $error("config echo wrong");
  unsol_idle_a: assert property (tx_valid && !b2_q && tx_byte[7] && !$past(tx_valid) |->
    !$past(link_busy) && !$past(cmd_valid)) else $error("unsolicited while busy");
  drop_unknown_a: assert property (take_w && !(cmd_code inside {8'h81, 8'h82, 8'h85, 8'h86}) |=> !tx_valid)
    else $error("unknown code answered");
endmodule
bind dhr_encoder dhr_encoder_monitor i_dhr_encoder_monitor (.*);

// ### bench/dhr_host_model.sv
`timescale 1ns/1ps
module dhr_host_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [7:0] rxq[$];
  logic ph = 1'b0;
  initial tx_ready = 1'b0;
  // A slow host takes every other cycle, so each offer must stand
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) rxq.push_back(tx_byte);
    ph <= !ph;
    tx_ready <= #1 !slow || ph;
  end
endmodule

// ### bench/test_driver_host_response_encoder.sv
`timescale 1ns/1ps
module test_driver_host_response_encoder;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_reject = 1'b0;
  logic link_busy = 1'b0;
  logic brn = 1'b0;
  logic us0 = 1'b0;
  logic slow = 1'b0;
  logic [7:0] f0 = 8'h00;
  logic [3:0] f1 = 4'h0;
  logic cmd_ready;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_byte;
  wire [4:0] cfg;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] wv [4] = '{8'hff, 8'h4a, 8'h05, 8'h00};
  always #10 ref_clk = !ref_clk;
  dhr_encoder i_dhr_encoder (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_reject(cmd_reject), .cmd_ready(cmd_ready), .link_busy(link_busy),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .brownout_event(brn),
    .flt_temp_warn(f0[0]), .flt_over_temp(f0[1]), .flt_in_uv(f0[2]), .flt_in_ov(f0[4]), .flt_buck_oc(f0[5]),
    .flt_buck_uv_warn(f0[6]), .flt_buck_uv_err(f0[7]), .flt_lin5_oc(f1[0]), .flt_lin12_oc(f1[1]),
    .flt_gate_undervoltage_lockout(f1[2]), .flt_ext_oc(f1[3]), .unsol_status0_req(us0),
    .cfg_pullup_disc(cfg[4]), .cfg_uv_lockout_dis(cfg[3]), .cfg_oc_dis(cfg[2]), .cfg_oc_thr(cfg[1:0]));
  dhr_host_model i_dhr_host_model (.ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rx2(input logic [7:0] e1, input logic [7:0] e2, input bit c2);
    int k;
    for (k = 0; k < 60 && i_dhr_host_model.rxq.size() < 2; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("msg_len", 8'h02, 8'(i_dhr_host_model.rxq.size()));
    if (i_dhr_host_model.rxq.size() >= 2) begin
      chk("byte1", e1, i_dhr_host_model.rxq.pop_front());
      if (c2) chk("byte2", e2, i_dhr_host_model.rxq.pop_front());
      else void'(i_dhr_host_model.rxq.pop_front());
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic r, input logic [7:0] e1,
    input logic [7:0] e2, input bit c2);
    cmd_code = c;
    cmd_data = d;
    cmd_reject = r;
    cmd_valid = 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    rx2(e1, e2, c2);
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("cfg_reset", 8'h00, {3'h0, cfg});
    rx2(8'h86, 8'h10, 1);
    cmd(8'h86, 8'h00, 0, 8'h46, 8'h10, 1);
    cmd(8'h86, 8'h00, 0, 8'h46, 8'h00, 1);
    cmd(8'h86, 8'h00, 1, 8'h06, 8'h00, 0);
    cmd(8'h85, 8'h00, 1, 8'h05, 8'h00, 0);
    $display("test start-up done");
    slow = 1'b1;
    for (int i = 0; i < 8; i++) begin
      f0 = 8'h01 << i;
      cmd(8'h85, 8'h00, 0, 8'h45, f0 & 8'hf7, 1);
    end
    f0 = 8'h00;
    for (int i = 0; i < 4; i++) begin
      f1 = 4'h1 << i;
      cmd(8'h86, 8'h00, 0, 8'h46, {4'h0, f1}, 1);
    end
    f1 = 4'h0;
    slow = 1'b0;
    $display("test flags done");
    foreach (wv[i]) begin
      cmd(8'h81, wv[i], 0, 8'h41, wv[i] & 8'h4f, 1);
      chk("cfg_ports", {3'h0, wv[i][6], wv[i][3:0]}, {3'h0, cfg});
      cmd(8'h82, 8'h00, 0, 8'h42, wv[i] & 8'h4f, 1);
    end
    cmd(8'h81, 8'h4f, 1, 8'h01, 8'h00, 0);
    cmd(8'h82, 8'h00, 1, 8'h02, 8'h00, 0);
    chk("cfg_kept", 8'h00, {3'h0, cfg});
    // A code this block does not own is taken and must draw no answer
    cmd_code = 8'h83;
    cmd_valid = 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 chk("unknown_drop", 8'h00, 8'(i_dhr_host_model.rxq.size()));
    $display("test config done");
    link_busy = 1'b1;
    f0 = 8'h90;
    us0 = 1'b1;
    brn = 1'b1;
    @(posedge ref_clk);
    #1 us0 = 1'b0;
    brn = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 chk("held_count", 8'h00, 8'(i_dhr_host_model.rxq.size()));
    link_busy = 1'b0;
    rx2(8'h86, 8'h10, 1);
    rx2(8'h85, 8'h90, 1);
    cmd(8'h86, 8'h00, 0, 8'h46, 8'h10, 1);
    $display("test unsolicited done");
    finish_test();
  end
endmodule
